/* File: rtl/adct_pkg.sv */
/*
  Shared constants, types and conversion-time tables for the converter timing block.
  Assumes a single system clock and a plain register port in the same domain.
*/
package adct_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 32'h0000_0032;
  localparam int DIV_SLOW = 32'h0000_0010;
  localparam int DIV_TURBO = 32'h0000_0008;
  localparam int START_DLY_NORMAL = 32'h0000_00D2;
  localparam int START_DLY_TURBO = 32'h0000_0072;
  localparam int WAKE_NORMAL_NS = 32'h0000_C350;
  localparam int WAKE_TURBO_NS = 32'h0000_61A8;
  // Longest waits round down to whole cycles.
  localparam int WAKE_NORMAL_CYC = WAKE_NORMAL_NS / CLK_PERIOD_NS;
  localparam int WAKE_TURBO_CYC = WAKE_TURBO_NS / CLK_PERIOD_NS;
  localparam int DATA_READY_N_PRE_CYC = 32'h0000_0004;

  // ****************************************
  // Widths and register map
  // ****************************************
  localparam int ADDR_W = 32'h0000_0008;
  localparam int DATA_W = 32'h0000_0020;
  localparam int CYC_W = 32'h0000_0014;
  localparam int ACC_W = 32'h0000_0010;
  localparam int WAKE_W = 32'h0000_000B;
  localparam int DIV_W = 32'h0000_0004;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATE = 8'h10;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_DUTY = 2'b01,
    MODE_TURBO = 2'b10
  } adct_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAKE = 2'b01,
    ST_DELAY = 2'b10,
    ST_CONV = 2'b11
  } adct_state_e;

  typedef logic [CYC_W-1:0] adct_cyc_t;
  typedef adct_cyc_t [0:2][0:6] adct_tbl_t;
  typedef logic [2:0] adct_rate_t;
  typedef logic [2:0] adct_gain_t;
  typedef logic [1:0] adct_line_t;

  localparam adct_rate_t RATE_MAX = 3'h6;
  localparam adct_rate_t RATE_NOTCH = 3'h0;
  localparam adct_gain_t GAIN_BYPASS_MAX = 3'h2;
  localparam adct_line_t LINE_NONE = 2'h0;

  typedef struct packed {
    logic amp_bypass_bit;
    adct_gain_t gain;
    adct_line_t line_rej;
    logic int_osc;
    logic cont;
    adct_rate_t rate;
    adct_mode_e mode;
  } adct_ctrl_s;
  localparam int CTRL_W = $bits(adct_ctrl_s);

  typedef struct packed {
    logic hold_off;
    logic overrun;
    logic done;
  } adct_evt_s;
  localparam int EVT_W = $bits(adct_evt_s);

  // ****************************************
  // Conversion times in system clock periods
  // ****************************************
  localparam adct_tbl_t CONT_TBL = '{
    '{20'h3_1FE0, 20'h1_63F0, 20'h0_B430, 20'h0_5C70, 20'h0_30B0, 20'h0_1AF0, 20'h0_1030},
    '{20'hC_8F50, 20'h5_9010, 20'h2_D110, 20'h1_7210, 20'h0_C310, 20'h0_6C10, 20'h0_4110},
    '{20'h1_8FF0, 20'h0_B1F8, 20'h0_5A18, 20'h0_2E38, 20'h0_1858, 20'h0_0D78, 20'h0_0818}
  };
  localparam adct_tbl_t SINGLE_TBL = '{
    '{20'h3_2032, 20'h1_6452, 20'h0_B492, 20'h0_5CD2, 20'h0_3112, 20'h0_1B52, 20'h0_1092},
    '{20'h0_0000, 20'h0_0000, 20'h0_0000, 20'h0_0000, 20'h0_0000, 20'h0_0000, 20'h0_0000},
    '{20'h1_9022, 20'h0_B232, 20'h0_5A52, 20'h0_2E72, 20'h0_1892, 20'h0_0DB2, 20'h0_0852}
  };

endpackage

/* File: rtl/adct_mod_div.sv */
/*
  Modulator clock divider: one enable pulse per modulator period.
  Assumes the enable comes from logic on the same clock.
*/
`timescale 1ns/100ps

module adct_mod_div (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic en,
  input wire logic turbo,
  // Modulator tick
  output logic tick
);

  typedef struct packed {
    logic [adct_pkg::DIV_W-1:0] cnt;
    logic tick;
    logic [adct_pkg::DIV_W:0] gap;
    logic seen;
  } adct_div_s;

  adct_div_s r_ff;
  adct_div_s nxt_r;
  logic [adct_pkg::DIV_W-1:0] term;

  always_comb begin
    term = turbo ? adct_pkg::DIV_W'(adct_pkg::DIV_TURBO - 1)
                 : adct_pkg::DIV_W'(adct_pkg::DIV_SLOW - 1);
    nxt_r = r_ff;
    nxt_r.tick = 1'b0;
    if (!en) begin
      nxt_r.cnt = '0;
    end else if (r_ff.cnt == term) begin
      nxt_r.cnt = '0;
      nxt_r.tick = 1'b1;
    end else begin
      nxt_r.cnt = r_ff.cnt + 1'b1;
    end
    nxt_r.gap = (r_ff.tick || !en) ? '0 : r_ff.gap + 1'b1;
    nxt_r.seen = en && (r_ff.seen || r_ff.tick);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign tick = r_ff.tick;

  mod_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    (r_ff.tick && r_ff.seen && $stable(turbo)) |-> r_ff.gap == {1'b0, term})
    else $error("Modulator tick spacing differs from the divide ratio.");

endmodule // adct_mod_div

/* File: rtl/adct_decim.sv */
/*
  Decimation filter: boxcar FIR that counts modulator ones over one conversion.
  Assumes clear is held outside conversions and pulses at each conversion end.
*/
`timescale 1ns/100ps

module adct_decim (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Modulator stream
  input wire logic tick,
  input wire logic mod_bit,
  input wire logic clr,
  // Running sum
  output logic [adct_pkg::ACC_W-1:0] acc
);

  typedef struct packed {
    logic [adct_pkg::ACC_W-1:0] acc;
  } adct_dec_s;

  adct_dec_s r_ff;
  adct_dec_s nxt_r;

  // Clearing at every conversion end keeps each result free of the last one.
  always_comb begin
    nxt_r = r_ff;
    if (clr) begin
      nxt_r.acc = '0;
    end else if (tick) begin
      nxt_r.acc = r_ff.acc + {{(adct_pkg::ACC_W-1){1'b0}}, mod_bit};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign acc = r_ff.acc;

  clear_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    clr |=> acc == '0)
    else $error("Filter sum not cleared at conversion boundary.");

endmodule // adct_decim

/* File: rtl/adct_top.sv */
/*
  Conversion timing and filter control: modes, start delays, oscillator wake-up,
  conversion-time table, data-ready output, register port and interrupt.
  Assumes a front end that raises SYNC_ACTIVE across the start/sync command
  bytes and forwards SCLK; both arrive from outside and are synchronised here.
*/
`timescale 1ns/100ps

// Operation
// - Modulator clock is system clock over 16, or over 8 in turbo.
// - FIR decimation filter settles fully within one conversion.
// - At 5 and 20 SPS a two-bit field picks 50, 60 or both.
// - Data rate and notches scale with the system clock frequency.
// - Continuous period runs from one data-ready fall to the next.
// - First continuous conversion starts 210 or 114 clocks after command end.
// - Single-shot time runs from command end to data-ready fall.
// - Internal oscillator adds up to 50 or 25 us wake-up in single-shot.
// - Oscillator powers up at the first SCLK rise of the command.
// - Single-shot conversion waits until the oscillator is fully running; continuous start clears the wake-up count.
// - Duty-cycle single-shot times equal normal single-shot times.
// - Normal mode follows its per-rate conversion-time table.
// - Duty-cycle continuous periods follow their per-rate table.
// - Turbo mode follows its per-rate conversion-time table.
// - Amplifier bypass takes effect only at gains 1, 2 and 4.
module adct_top #(
  parameter adct_pkg::adct_tbl_t CONT_CYC = adct_pkg::CONT_TBL,
  parameter adct_pkg::adct_tbl_t SINGLE_CYC = adct_pkg::SINGLE_TBL
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register port
  input wire logic [adct_pkg::ADDR_W-1:0] ADDR,
  input wire logic [adct_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [adct_pkg::DATA_W-1:0] RDATA,
  output logic IRQ,
  // Command pins
  input wire logic SCLK,
  input wire logic SYNC_ACTIVE,
  // Modulator stream
  input wire logic MOD_BIT,
  output logic MOD_CLK_EN,
  // Status and analog control
  output logic DATA_READY_N,
  output logic OSC_EN,
  output logic [1:0] LINE_REJ,
  output logic AMP_BYPASS
);

  // ****************************************
  // State
  // ****************************************
  localparam int DLY_N = adct_pkg::START_DLY_NORMAL;
  localparam int DLY_T = adct_pkg::START_DLY_TURBO;
  localparam int WAKE_N = adct_pkg::WAKE_NORMAL_CYC;

  typedef struct packed {
    adct_pkg::adct_state_e st;
    adct_pkg::adct_cyc_t cnt;
    logic [adct_pkg::WAKE_W-1:0] wake;
    adct_pkg::adct_ctrl_s ctrl;
    adct_pkg::adct_evt_s status;
    adct_pkg::adct_evt_s mask;
    logic [adct_pkg::DATA_W-1:0] rdata;
    logic irq;
    logic data_ready_n_n;
    logic [adct_pkg::ACC_W-1:0] result;
    logic unread;
    logic osc_en;
    adct_pkg::adct_line_t line;
    logic byp;
    logic [1:0] sclk_m;
    logic [1:0] sync_m;
    logic [1:0] bit_m;
    logic sclk_d;
    logic sync_d;
    adct_pkg::adct_cyc_t since;
    logic first;
  } adct_top_s;

  adct_top_s r_ff;
  adct_top_s nxt_r;

  // ****************************************
  // Decode
  // ****************************************
  adct_pkg::adct_mode_e mode_eff;
  adct_pkg::adct_mode_e mode_single;
  adct_pkg::adct_rate_t rate_eff;
  adct_pkg::adct_cyc_t cont_cyc;
  adct_pkg::adct_cyc_t sing_cyc;
  adct_pkg::adct_cyc_t dly_cyc;
  logic [adct_pkg::WAKE_W-1:0] wake_cyc;
  logic turbo;
  logic cmd_end;
  logic sclk_rise;
  logic conv_end;
  logic osc_ready;
  logic dec_clr;
  logic mod_tick;
  logic [adct_pkg::ACC_W-1:0] dec_acc;

  always_comb begin
    // A reserved mode code runs as normal rather than stalling the sequencer.
    mode_eff = (r_ff.ctrl.mode == adct_pkg::MODE_TURBO ||
                r_ff.ctrl.mode == adct_pkg::MODE_DUTY) ? r_ff.ctrl.mode
                                                       : adct_pkg::MODE_NORMAL;
    mode_single = (mode_eff == adct_pkg::MODE_DUTY) ? adct_pkg::MODE_NORMAL : mode_eff;
    rate_eff = (r_ff.ctrl.rate > adct_pkg::RATE_MAX) ? adct_pkg::RATE_MAX
                                                     : r_ff.ctrl.rate;
    turbo = (mode_eff == adct_pkg::MODE_TURBO);
    // Counts are in system clocks, so rate and notches follow the clock.
    cont_cyc = CONT_CYC[mode_eff][rate_eff];
    sing_cyc = SINGLE_CYC[mode_single][rate_eff];
    dly_cyc = turbo ? adct_pkg::CYC_W'(adct_pkg::START_DLY_TURBO - 2)
                    : adct_pkg::CYC_W'(adct_pkg::START_DLY_NORMAL - 2);
    wake_cyc = turbo ? adct_pkg::WAKE_W'(adct_pkg::WAKE_TURBO_CYC)
                     : adct_pkg::WAKE_W'(adct_pkg::WAKE_NORMAL_CYC);
    cmd_end = r_ff.sync_d && !r_ff.sync_m[1];
    sclk_rise = r_ff.sclk_m[1] && !r_ff.sclk_d;
    conv_end = (r_ff.st == adct_pkg::ST_CONV) && (r_ff.cnt == '0);
    osc_ready = r_ff.osc_en && (r_ff.wake == '0);
    dec_clr = (r_ff.st != adct_pkg::ST_CONV) || (r_ff.cnt == '0);
  end

  // ****************************************
  // Modulator and filter
  // ****************************************
  adct_mod_div u_div (
    .clk(CLOCK),
    .rst_n(RST_N),
    .en(r_ff.st == adct_pkg::ST_CONV),
    .turbo(turbo),
    .tick(mod_tick)
  );

  adct_decim u_dec (
    .clk(CLOCK),
    .rst_n(RST_N),
    .tick(mod_tick),
    .mod_bit(r_ff.bit_m[1]),
    .clr(dec_clr),
    .acc(dec_acc)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_r = r_ff;
    nxt_r.sclk_m = {r_ff.sclk_m[0], SCLK};
    nxt_r.sync_m = {r_ff.sync_m[0], SYNC_ACTIVE};
    nxt_r.bit_m = {r_ff.bit_m[0], MOD_BIT};
    nxt_r.sclk_d = r_ff.sclk_m[1];
    nxt_r.sync_d = r_ff.sync_m[1];
    nxt_r.rdata = '0;

    // Register writes; status clears first so hardware sets below win.
    if (WR) begin
      case (ADDR)
        adct_pkg::OFS_CTRL: begin
          nxt_r.ctrl = adct_pkg::adct_ctrl_s'(WDATA[adct_pkg::CTRL_W-1:0]);
        end
        adct_pkg::OFS_STATUS: begin
          nxt_r.status = r_ff.status & ~adct_pkg::adct_evt_s'(WDATA[adct_pkg::EVT_W-1:0]);
        end
        adct_pkg::OFS_MASK: begin
          nxt_r.mask = adct_pkg::adct_evt_s'(WDATA[adct_pkg::EVT_W-1:0]);
        end
        default: begin
        end
      endcase
    end

    // Register reads; answer stands only in the next cycle.
    if (RD) begin
      case (ADDR)
        adct_pkg::OFS_CTRL: nxt_r.rdata = adct_pkg::DATA_W'(r_ff.ctrl);
        adct_pkg::OFS_STATUS: nxt_r.rdata = adct_pkg::DATA_W'(r_ff.status);
        adct_pkg::OFS_MASK: nxt_r.rdata = adct_pkg::DATA_W'(r_ff.mask);
        adct_pkg::OFS_RESULT: begin
          nxt_r.rdata = adct_pkg::DATA_W'(r_ff.result);
          nxt_r.unread = 1'b0;
          nxt_r.data_ready_n_n = 1'b1;
        end
        adct_pkg::OFS_STATE: begin
          nxt_r.rdata = adct_pkg::DATA_W'({r_ff.data_ready_n_n, osc_ready, r_ff.st});
        end
        default: nxt_r.rdata = '0;
      endcase
    end

    // Oscillator wake-up count.
    if (r_ff.osc_en && r_ff.wake != '0) begin
      nxt_r.wake = r_ff.wake - 1'b1;
    end

    // Conversion sequencer.
    case (r_ff.st)
      adct_pkg::ST_IDLE: begin
      end
      adct_pkg::ST_WAKE: begin
        if (osc_ready) begin
          nxt_r.st = adct_pkg::ST_CONV;
          nxt_r.cnt = sing_cyc - 1'b1;
        end
      end
      adct_pkg::ST_DELAY: begin
        if (r_ff.cnt == '0) begin
          nxt_r.st = adct_pkg::ST_CONV;
          nxt_r.cnt = cont_cyc - 1'b1;
        end else begin
          nxt_r.cnt = r_ff.cnt - 1'b1;
        end
      end
      adct_pkg::ST_CONV: begin
        if (conv_end) begin
          nxt_r.data_ready_n_n = 1'b0;
          nxt_r.result = dec_acc;
          nxt_r.unread = 1'b1;
          nxt_r.status.done = 1'b1;
          nxt_r.status.overrun = r_ff.status.overrun || r_ff.unread;
          if (r_ff.ctrl.cont) begin
            nxt_r.cnt = cont_cyc - 1'b1;
          end else begin
            nxt_r.st = adct_pkg::ST_IDLE;
            nxt_r.osc_en = 1'b0;
          end
        end else begin
          nxt_r.cnt = r_ff.cnt - 1'b1;
          // Raising early guarantees a falling edge even if the result went unread.
          if (r_ff.cnt == adct_pkg::CYC_W'(adct_pkg::DATA_READY_N_PRE_CYC)) begin
            nxt_r.data_ready_n_n = 1'b1;
          end
        end
      end
      default: begin
        nxt_r.st = adct_pkg::ST_IDLE;
      end
    endcase

    // Oscillator power-up on the first clock edge of the command.
    if (sclk_rise && r_ff.sync_m[1] && r_ff.ctrl.int_osc && !r_ff.osc_en) begin
      nxt_r.osc_en = 1'b1;
      nxt_r.wake = wake_cyc;
    end

    // Start/sync command end restarts the sequence.
    if (cmd_end) begin
      nxt_r.data_ready_n_n = 1'b1;
      if (r_ff.ctrl.cont) begin
        nxt_r.st = adct_pkg::ST_DELAY;
        nxt_r.cnt = dly_cyc;
        nxt_r.osc_en = r_ff.ctrl.int_osc;
        nxt_r.wake = '0;
      end else if (r_ff.ctrl.int_osc && !osc_ready) begin
        nxt_r.st = adct_pkg::ST_WAKE;
        nxt_r.status.hold_off = 1'b1;
        if (!r_ff.osc_en) begin
          nxt_r.osc_en = 1'b1;
          nxt_r.wake = wake_cyc;
        end
      end else begin
        nxt_r.st = adct_pkg::ST_CONV;
        nxt_r.cnt = sing_cyc - 2'd2;
      end
    end

    // Filter and amplifier controls.
    nxt_r.line = (rate_eff == adct_pkg::RATE_NOTCH && !turbo) ? r_ff.ctrl.line_rej
                                                              : adct_pkg::LINE_NONE;
    nxt_r.byp = r_ff.ctrl.amp_bypass_bit &&
                (r_ff.ctrl.gain <= adct_pkg::GAIN_BYPASS_MAX);
    nxt_r.irq = |(r_ff.status & r_ff.mask);

    // Timing observers.
    nxt_r.since = (cmd_end || conv_end) ? '0 : r_ff.since + 1'b1;
    nxt_r.first = cmd_end || (r_ff.first && !conv_end);
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      r_ff <= '0;
      r_ff.data_ready_n_n <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign RDATA = r_ff.rdata;
  assign IRQ = r_ff.irq;
  assign MOD_CLK_EN = mod_tick;
  assign DATA_READY_N = r_ff.data_ready_n_n;
  assign OSC_EN = r_ff.osc_en;
  assign LINE_REJ = r_ff.line;
  assign AMP_BYPASS = r_ff.byp;

  // ****************************************
  // Checks
  // ****************************************
  start_delay_normal_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (cmd_end && r_ff.ctrl.cont && !turbo) ##1 (!cmd_end)[*8] |-> ##(DLY_N - 8)
      r_ff.st == adct_pkg::ST_CONV)
    else $error("Continuous start delay wrong in normal mode.");

  start_delay_turbo_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (cmd_end && r_ff.ctrl.cont && turbo) ##1 (!cmd_end)[*8] |-> ##(DLY_T - 8)
      r_ff.st == adct_pkg::ST_CONV)
    else $error("Continuous start delay wrong in turbo mode.");

  cont_period_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    ($fell(DATA_READY_N) && !$past(r_ff.first) && r_ff.ctrl.cont && $stable(r_ff.ctrl))
      |-> $past(r_ff.since) == cont_cyc - 1'b1)
    else $error("Continuous period differs from the table.");

  single_time_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    ($fell(DATA_READY_N) && $past(r_ff.first) && !r_ff.ctrl.cont && !r_ff.ctrl.int_osc)
      |-> $past(r_ff.since) == sing_cyc - 2'd2)
    else $error("Single-shot time differs from the table.");

  wake_bound_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    $rose(r_ff.st == adct_pkg::ST_WAKE) |-> ##[1:WAKE_N] r_ff.st != adct_pkg::ST_WAKE)
    else $error("Oscillator wait exceeds the wake-up time.");

  wake_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (r_ff.st == adct_pkg::ST_WAKE && r_ff.wake != '0) |=> r_ff.st != adct_pkg::ST_CONV)
    else $error("Conversion started before the oscillator was ready.");

  osc_start_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (sclk_rise && r_ff.sync_m[1] && r_ff.ctrl.int_osc && !OSC_EN) |=> OSC_EN)
    else $error("Oscillator did not start on the command clock.");

  line_rej_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (LINE_REJ != adct_pkg::LINE_NONE) |->
      $past(rate_eff) == adct_pkg::RATE_NOTCH && !$past(turbo))
    else $error("Line rejection active at an unsupported rate.");

  bypass_gain_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    AMP_BYPASS |-> $past(r_ff.ctrl.gain) <= adct_pkg::GAIN_BYPASS_MAX)
    else $error("Amplifier bypassed at a gain above four.");

  done_irq_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (conv_end && r_ff.mask.done) |=> ##1 IRQ)
    else $error("Conversion end did not raise the interrupt.");

endmodule // adct_top

/* File: verification/adct_host_model.sv */
/*
  Host command model: drives SCLK and SYNC_ACTIVE for one start/sync command byte.
  Assumes the bench pulses send once per command and that no command overlaps another.
*/
`timescale 1ns/100ps

module adct_host_model (
  // Command request
  input wire logic send,
  input wire logic [15:0] half_ns,
  // Command pins
  output logic sclk,
  output logic sync_active,
  output logic busy
);
  initial begin
    sclk = 1'b0;
    sync_active = 1'b0;
    busy = 1'b0;
  end

  // SCLK idles low between commands, so no stray edge can start the oscillator.
  always @(posedge send) begin
    busy = 1'b1;
    // Pin edges sit between system clock edges, so the synchronisers never race.
    #(half_ns / 8);
    sync_active = 1'b1;
    repeat (8) begin
      #(half_ns) sclk = 1'b1;
      #(half_ns) sclk = 1'b0;
    end
    #(half_ns) sync_active = 1'b0;
    busy = 1'b0;
  end
endmodule // adct_host_model

/* File: verification/testbench.sv */
/*
  Self-checking bench for the conversion timing block, with a host command model.
  Assumes short conversion tables handed in as parameters and a 20 MHz system clock.
*/
`timescale 1ns/100ps

module testbench;
  logic clock, rst_n, wr_s, rd_s, mod_bit, send, sclk, sync_active, busy;
  logic irq, mclk_en, data_ready_n_n, osc_en, amp_byp;
  logic [1:0] line_rej;
  logic [7:0] addr;
  logic [15:0] half;
  logic [31:0] wdata, rdata, rv;
  int err_total, checks;

  // ****************************************
  // Short tables keep each conversion brief
  // ****************************************
  function automatic adct_pkg::adct_tbl_t mk(int base);
    adct_pkg::adct_tbl_t t;
    for (int m = 0; m < 3; m++) begin
      for (int r = 0; r < 7; r++) begin
        t[m][r] = 20'(base + 10 * m + 2 * r);
      end
    end
    return t;
  endfunction
  localparam adct_pkg::adct_tbl_t T_CONT = mk(60);
  localparam adct_pkg::adct_tbl_t T_SING = mk(90);

  adct_top #(.CONT_CYC(T_CONT), .SINGLE_CYC(T_SING)) i_dut (
    .CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .IRQ(irq), .SCLK(sclk), .SYNC_ACTIVE(sync_active), .MOD_BIT(mod_bit),
    .MOD_CLK_EN(mclk_en), .DATA_READY_N(data_ready_n_n), .OSC_EN(osc_en), .LINE_REJ(line_rej),
    .AMP_BYPASS(amp_byp));

  adct_host_model i_host (.send(send), .half_ns(half), .sclk(sclk),
    .sync_active(sync_active), .busy(busy));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic stop(string nm);
    err_total++;
    $display("BAD %s wait ran out", nm);
    wrap_up();
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic chk_rng(string nm, int lo, int hi, logic [31:0] got);
    checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      err_total++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    tick(8);
    rst_n <= 1'b1;
    tick(1);
  endtask

  // A gap cycle after a write keeps the strobe from being driven twice at one edge.
  task automatic wr(logic [7:0] a, logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    tick(1);
    wr_s <= 1'b0;
    tick(1);
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd_s <= 1'b1;
    tick(1);
    rd_s <= 1'b0;
    tick(1);
    d = rdata;
  endtask

  function automatic logic [31:0] ctl(int m, int r, int c, int o);
    return 32'(m + (r << 2) + (c << 5) + (o << 6));
  endfunction

  // Counts edges from the request to the data-ready fall, and from command end.
  task automatic cmd(output int n, output int na);
    int nb;
    nb = 0;
    n = 0;
    tick(1);
    half = 16'd100;
    send <= 1'b1;
    while (data_ready_n_n !== 1'b0) begin
      tick(1);
      send <= 1'b0;
      n++;
      if (nb == 0 && n > 1 && busy === 1'b0) begin
        nb = n;
      end
      if (n > 5000) begin
        stop("data ready");
      end
    end
    na = n - nb;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_regs;
    logic [7:0] a [6] = '{adct_pkg::OFS_CTRL, adct_pkg::OFS_STATUS, adct_pkg::OFS_MASK,
      adct_pkg::OFS_RESULT, adct_pkg::OFS_STATE, 8'h14};
    wr(8'h14, 32'hFFFF_FFFF);
    chk("osc off", 32'(1'b0), 32'(osc_en));
    foreach (a[i]) begin
      rd(a[i], rv);
      chk("reset read", (a[i] == adct_pkg::OFS_STATE) ? 32'h0000_0008 : 32'h0000_0000, rv);
    end
  endtask

  task automatic s_line;
    logic [31:0] c [8] = '{32'h0000_0180, 32'h0000_0081, 32'h0000_0184, 32'h0000_0102,
      32'h0000_1400, 32'h0000_1600, 32'h0000_0183, 32'h0000_019C};
    logic [2:0] e [8] = '{3'h3, 3'h1, 3'h0, 3'h0, 3'h4, 3'h0, 3'h3, 3'h0};
    foreach (c[i]) begin
      wr(adct_pkg::OFS_CTRL, c[i]);
      tick(2);
      chk("line and bypass", 32'(e[i]), 32'({amp_byp, line_rej}));
    end
  endtask

  task automatic s_single;
    int n, na, row, dv, s;
    for (int m = 0; m < 3; m++) begin
      for (int r = 0; r < 7; r += 6) begin
        row = (m == 1) ? 0 : m;
        dv = (m == 2) ? 8 : 16;
        s = T_SING[row][r];
        do_reset();
        wr(adct_pkg::OFS_CTRL, ctl(m, r, 0, 0));
        cmd(n, na);
        chk_rng("single time", s + 1, s + 5, 32'(na));
        rd(adct_pkg::OFS_RESULT, rv);
        chk_rng("result", s / dv - 2, s / dv + 1, rv);
      end
    end
  endtask

  task automatic s_cont;
    int n, na, p, dly;
    logic hi;
    for (int m = 0; m < 3; m++) begin
      p = T_CONT[m][3];
      dly = (m == 2) ? adct_pkg::START_DLY_TURBO : adct_pkg::START_DLY_NORMAL;
      do_reset();
      wr(adct_pkg::OFS_CTRL, ctl(m, 3, 1, 0));
      cmd(n, na);
      chk_rng("first fall", dly + p + 1, dly + p + 5, 32'(na));
      n = 0;
      hi = 1'b0;
      while (!(hi && data_ready_n_n === 1'b0)) begin
        tick(1);
        n++;
        hi = hi | (data_ready_n_n === 1'b1);
        if (n > 2000) begin
          stop("period");
        end
      end
      chk("period", 32'(p), 32'(n));
      rd(adct_pkg::OFS_STATUS, rv);
      chk("overrun", 32'h0000_0002, rv & 32'h0000_0002);
      for (int k = 0; k < 40 && mclk_en !== 1'b1; k++) begin
        tick(1);
      end
      n = 0;
      do begin
        tick(1);
        n++;
      end while (mclk_en !== 1'b1 && n < 40);
      chk("modulator divide", 32'((m == 2) ? 8 : 16), 32'(n));
    end
  endtask

  task automatic s_osc;
    int n, na, w, s;
    for (int m = 0; m < 3; m += 2) begin
      w = (m == 2) ? adct_pkg::WAKE_TURBO_CYC : adct_pkg::WAKE_NORMAL_CYC;
      s = T_SING[m][6];
      do_reset();
      wr(adct_pkg::OFS_CTRL, ctl(m, 6, 0, 1));
      cmd(n, na);
      chk_rng("wake time", w + s + 2, w + s + 9, 32'(n));
      rd(adct_pkg::OFS_STATUS, rv);
      chk("hold off", 32'h0000_0004, rv & 32'h0000_0004);
    end
  endtask

  task automatic s_irq;
    int n, na;
    do_reset();
    wr(adct_pkg::OFS_MASK, 32'h0000_0001);
    wr(adct_pkg::OFS_CTRL, ctl(0, 6, 0, 0));
    cmd(n, na);
    tick(2);
    chk("irq raised", 32'h0000_0001, 32'(irq));
    rd(adct_pkg::OFS_STATUS, rv);
    chk("done status", 32'h0000_0001, rv);
    wr(adct_pkg::OFS_STATUS, 32'h0000_0001);
    tick(2);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    wr(adct_pkg::OFS_MASK, 32'h0000_0000);
    rd(adct_pkg::OFS_RESULT, rv);
    mod_bit <= 1'b0;
    cmd(n, na);
    tick(2);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    rd(adct_pkg::OFS_RESULT, rv);
    chk("zero result", 32'h0000_0000, rv);
  endtask

  initial begin
    rst_n = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    mod_bit = 1'b1;
    send = 1'b0;
    half = 16'd100;
    err_total = 0;
    checks = 0;
    do_reset();
    s_regs();
    s_line();
    s_single();
    s_cont();
    s_osc();
    s_irq();
    wrap_up();
  end
endmodule // testbench
